// File: bus_error_agent_model.sv
// Bus agent model that raises error events toward the logger
`timescale 1ns/1ps
`default_nettype none
module bus_error_agent_model (
  input wire logic hclk,
  output var bus_error_status_logger_pkg::err_event_t ev
);
  initial ev = '0;
  // One high cycle only, since every high cycle counts as an event
  // Context bits: corrupt, restartable, pointer related
  task fire(input logic [4:0] k, input logic [7:0] s,
            input logic [2:0] c = 3'h0);
    @(posedge hclk);
    ev <= bus_error_status_logger_pkg::err_event_t'({k, s, c});
    @(posedge hclk);
    ev <= '0;
  endtask
endmodule
`default_nettype wire

// File: bus_error_event_latch.sv
// Sticky error status bank with syndrome capture
`timescale 1ns/1ps
`default_nettype none
`include "bus_error_status_logger_cfg.svh"
module bus_error_event_latch (
  input wire logic hclk,
  input wire logic hresetn,
  input wire bus_error_status_logger_pkg::err_event_t ev,
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic wr_glb,
  input wire logic [31:0] wdata,
  output logic [63:0] status,
  output logic [2:0] glb,
  output logic trap_pulse,
  output logic shutdown
);
  bus_error_status_logger_pkg::bank_state_t s_r;
  bus_error_status_logger_pkg::bank_state_t s_nxt;
  logic any_err;
  logic unrec;
  logic shut_r;
  logic trap_r;

  // Event folding; set wins over a clearing write in the same cycle
  always_comb begin
    s_nxt = s_r;
    any_err = ev.hard_err | ev.internal_failure_pin |
              ev.address_parity_failure | ev.ecc_uncorrected |
              ev.ecc_corrected;
    unrec = ev.context_corrupt | ~ev.restart_ok | s_r.status[`BESL_BIT_VALID];
    // Writing zero clears a status word; nonzero status words are ignored, a global write of any value stores only wdata bit 2 (check_in_progress)
    if (wr_lo && wdata == 32'h0) begin
      s_nxt.status[31:0] = 32'h0;
    end
    if (wr_hi && wdata == 32'h0) begin
      s_nxt.status[63:32] = 32'h0;
      s_nxt.apar_cnt = 2'h0;
    end
    if (wr_glb) begin
      s_nxt.check_in_progress = wdata[`BESL_G_CHECK_IN_PROGRESS];
    end
    if (ev.hard_err) begin
      s_nxt.status[`BESL_BIT_HARD] = 1'b1;
    end
    if (ev.internal_failure_pin) begin
      s_nxt.status[`BESL_BIT_INTERNAL_FAILURE_PIN] = 1'b1;
    end
    if (ev.address_parity_failure && s_nxt.apar_cnt != `BESL_APAR_LIMIT) begin
      s_nxt.apar_cnt = s_nxt.apar_cnt + 2'h1;
    end
    if (s_nxt.apar_cnt == `BESL_APAR_LIMIT) begin
      s_nxt.status[`BESL_BIT_APAR] = 1'b1;
    end
    // Syndrome held while an uncorrected one is logged
    if ((ev.ecc_uncorrected || ev.ecc_corrected) &&
        !s_r.status[`BESL_BIT_UNCOR]) begin
      s_nxt.status[`BESL_SYN_HI:`BESL_SYN_LO] = ev.syndrome;
    end
    if (ev.ecc_uncorrected) begin
      s_nxt.status[`BESL_BIT_UNCOR] = 1'b1;
      s_nxt.status[`BESL_BIT_NOTFIX] = 1'b1;
    end
    if (ev.ecc_corrected) begin
      s_nxt.status[`BESL_BIT_COR] = 1'b1;
    end
    if (any_err) begin
      s_nxt.status[`BESL_BIT_OVER] = s_r.status[`BESL_BIT_VALID] |
                                     s_nxt.status[`BESL_BIT_OVER];
      s_nxt.status[`BESL_BIT_VALID] = 1'b1;
      if (ev.context_corrupt) begin
        s_nxt.status[`BESL_BIT_PCC] = 1'b1;
      end
    end
    // Corrected errors raise no trap; others are aborts
    if (any_err && !(ev.ecc_corrected && !ev.ecc_uncorrected &&
        !ev.hard_err && !ev.internal_failure_pin &&
        !ev.address_parity_failure)) begin
      s_nxt.check_in_progress = 1'b1;
      s_nxt.restart_pointer_ok = ev.restart_ok & ~unrec;
      s_nxt.error_pointer_ok = unrec & ev.error_ip_related;
    end
    s_nxt.status[56:55] = 2'h0;
  end

  // Trap pulse and shutdown on recursion
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
      trap_r <= 1'b0;
      shut_r <= 1'b0;
    end else begin
      s_r <= s_nxt;
      trap_r <= s_nxt.check_in_progress & ~s_r.check_in_progress;
      shut_r <= shut_r | (s_r.check_in_progress & s_nxt.check_in_progress & any_err &
                !(ev.ecc_corrected && !ev.ecc_uncorrected &&
                  !ev.hard_err && !ev.internal_failure_pin &&
                  !ev.address_parity_failure));
    end
  end

  assign status = s_r.status;
  assign glb = {s_r.check_in_progress, s_r.error_pointer_ok, s_r.restart_pointer_ok};
  assign trap_pulse = trap_r;
  assign shutdown = shut_r;
endmodule
`default_nettype wire

// File: bus_error_status_logger.sv
// AHB-Lite register front end of the bus error status logger
//
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "bus_error_status_logger_cfg.svh"
module bus_error_status_logger #(
  parameter int BANK_COUNT = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire bus_error_status_logger_pkg::err_event_t ev,
  output logic trap_pulse,
  output logic [7:0] trap_vector,
  output logic unrecoverable,
  output logic shutdown
);
  typedef struct packed {
    bus_error_status_logger_pkg::ahb_phase_t ph;
    logic [11:0] addr;
    logic [31:0] rdata;
  } fe_state_t;

  fe_state_t f_r;
  fe_state_t f_nxt;
  logic [63:0] status;
  logic [2:0] glb;
  logic wr_lo;
  logic wr_hi;
  logic wr_glb;
  logic [31:0] rd_word;

  // Only a single bank is built; other counts refused at elaboration
  if (BANK_COUNT != 1) begin : g_bank_count_check
    $error("bus_error_status_logger: only one bank supported");
  end

  // Write strobes in the data phase; hsize is not decoded
  always_comb begin
    wr_lo = f_r.ph == bus_error_status_logger_pkg::AHB_WRITE &&
            f_r.addr == `BESL_OFF_STAT_LO;
    wr_hi = f_r.ph == bus_error_status_logger_pkg::AHB_WRITE &&
            f_r.addr == `BESL_OFF_STAT_HI;
    wr_glb = f_r.ph == bus_error_status_logger_pkg::AHB_WRITE &&
             f_r.addr == `BESL_OFF_GLOBAL;
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    case (haddr[11:0])
      `BESL_OFF_STAT_LO: rd_word = status[31:0];
      `BESL_OFF_STAT_HI: rd_word = status[63:32];
      `BESL_OFF_GLOBAL: rd_word = {29'h0, glb};
      `BESL_OFF_CAP: rd_word = {24'h0, 8'(BANK_COUNT)};
      `BESL_OFF_EVENT: rd_word = {31'h0, shutdown};
      default: rd_word = 32'h0;
    endcase
  end

  // Address phase capture; zero wait states so hready is ours
  always_comb begin
    f_nxt = f_r;
    f_nxt.ph = bus_error_status_logger_pkg::AHB_IDLE;
    if (hsel && hready && htrans[1]) begin
      f_nxt.addr = haddr[11:0];
      f_nxt.ph = hwrite ? bus_error_status_logger_pkg::AHB_WRITE :
                          bus_error_status_logger_pkg::AHB_READ;
      if (!hwrite) begin
        f_nxt.rdata = rd_word;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end

  bus_error_event_latch u_latch (
    .hclk(hclk),
    .hresetn(hresetn),
    .ev(ev),
    .wr_lo(wr_lo),
    .wr_hi(wr_hi),
    .wr_glb(wr_glb),
    .wdata(hwdata),
    .status(status),
    .glb(glb),
    .trap_pulse(trap_pulse),
    .shutdown(shutdown)
  );

  // Unrecoverable when corrupt, overflowed or not restartable
  assign unrecoverable = status[`BESL_BIT_VALID] &
                         (status[`BESL_BIT_PCC] | status[`BESL_BIT_OVER] |
                          (glb[2] & ~glb[0]));
  assign trap_vector = `BESL_TRAP_VECTOR;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = f_r.rdata;
endmodule
`default_nettype wire

// File: bus_error_status_logger_cfg.svh
// Register offsets, field positions, trap vector and parity limit for the logger
`ifndef BUS_ERROR_STATUS_LOGGER_CFG_SVH
`define BUS_ERROR_STATUS_LOGGER_CFG_SVH
`define BESL_BANK0_BASE 12'h400
`define BESL_OFF_STAT_LO 12'h400
`define BESL_OFF_STAT_HI 12'h404
`define BESL_OFF_GLOBAL 12'h408
`define BESL_OFF_CAP 12'h40c
`define BESL_OFF_EVENT 12'h410
`define BESL_BIT_HARD 42
`define BESL_BIT_INTERNAL_FAILURE_PIN 43
`define BESL_BIT_APAR 44
`define BESL_BIT_UNCOR 45
`define BESL_BIT_COR 46
`define BESL_SYN_LO 47
`define BESL_SYN_HI 54
`define BESL_BIT_PCC 57
`define BESL_BIT_NOTFIX 61
`define BESL_BIT_OVER 62
`define BESL_BIT_VALID 63
`define BESL_G_RESTART_POINTER_OK 0
`define BESL_G_ERROR_POINTER_OK 1
`define BESL_G_CHECK_IN_PROGRESS 2
`define BESL_TRAP_VECTOR 8'h12
`define BESL_APAR_LIMIT 2'h2
`endif

// File: bus_error_status_logger_pkg.sv
// Types shared by the bus error status logger
`default_nettype none
package bus_error_status_logger_pkg;
  typedef struct packed {
    logic hard_err;
    logic internal_failure_pin;
    logic address_parity_failure;
    logic ecc_uncorrected;
    logic ecc_corrected;
    logic [7:0] syndrome;
    logic context_corrupt;
    logic restart_ok;
    logic error_ip_related;
  } err_event_t;
  typedef struct packed {
    logic [63:0] status;
    logic [1:0] apar_cnt;
    logic restart_pointer_ok;
    logic error_pointer_ok;
    logic check_in_progress;
  } bank_state_t;
  typedef enum logic [1:0] {
    AHB_IDLE = 2'b00,
    AHB_READ = 2'b01,
    AHB_WRITE = 2'b11
  } ahb_phase_t;
endpackage
`default_nettype wire

// File: bus_error_status_logger_sva.sv
// Port-level assertions for the bus error status logger
`timescale 1ns/1ps
`default_nettype none
module bus_error_status_logger_sva #(
  parameter int BANK_COUNT = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic trap_pulse,
  input wire logic [7:0] trap_vector,
  input wire logic shutdown
);
  // Read address phase taken at this edge
  wire logic rd_a;
  assign rd_a = hsel && hready && htrans[1] && !hwrite;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_ready; hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("hreadyout low");
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("hresp not okay");
  property p_vec; trap_vector == 8'h12; endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_trap; trap_pulse |=> !trap_pulse; endproperty
  a_trap: assert property (p_trap) else $error("long trap");
  property p_shut; shutdown |=> shutdown; endproperty
  a_shut: assert property (p_shut) else $error("shutdown lost");
  property p_cap; rd_a && haddr == 32'h40c |=> hrdata == 32'(BANK_COUNT);
  endproperty
  a_cap: assert property (p_cap) else $error("bad count");
  property p_res; rd_a && haddr == 32'h404 |=> hrdata[24:23] == 2'h0;
  endproperty
  a_res: assert property (p_res) else $error("reserved set");
  property p_unm; rd_a && haddr == 32'h500 |=> hrdata == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped data");
endmodule
bind bus_error_status_logger bus_error_status_logger_sva #(
  .BANK_COUNT(BANK_COUNT)
) chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .hrdata, .trap_pulse, .trap_vector, .shutdown);
`default_nettype wire

// File: bus_error_status_logger_tb_top.sv
// Self-checking bench for the bus error status logger
`timescale 1ns/1ps
`default_nettype none
module bus_error_status_logger_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire logic hready;
  logic hreadyout, hresp, trap_pulse, unrecoverable, shutdown;
  logic [31:0] hrdata, r;
  logic [7:0] trap_vector;
  bus_error_status_logger_pkg::err_event_t ev;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int ntrap = 0;
  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  always #2 hclk = ~hclk;
  bus_error_status_logger #(.BANK_COUNT(1)) dut (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp,
    .hrdata, .ev, .trap_pulse, .trap_vector, .unrecoverable, .shutdown);
  bus_error_agent_model agent (.hclk, .ev);
  task wrap_up;
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Trap count and a hang limit well above the run length
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (trap_pulse === 1'b1) ntrap <= ntrap + 1;
    if (cyc == 5000) begin
      err_count++;
      wrap_up;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One single AHB-Lite word transfer; read data lands in r
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task t_reset;
    xfer(1'b0, 32'h400, 32'h0);
    chk(r, 32'h0);
    xfer(1'b0, 32'h404, 32'h0);
    chk(r, 32'h0);
  endtask
  task t_hard;
    agent.fire(5'h10, 8'h0);
    xfer(1'b0, 32'h404, 32'h0);
    chk(r & 32'hc000_0400, 32'h8000_0400);
    chk(32'(ntrap), 32'h1);
    chk({31'h0, unrecoverable}, 32'h1);
    xfer(1'b0, 32'h400, 32'h0);
    chk(r, 32'h0);
    xfer(1'b0, 32'h408, 32'h0);
    chk(r & 32'h4, 32'h4);
    xfer(1'b1, 32'h408, 32'h0);
    xfer(1'b1, 32'h404, 32'h0);
    xfer(1'b0, 32'h404, 32'h0);
    chk(r & 32'hc000_0400, 32'h0);
    chk({31'h0, unrecoverable}, 32'h0);
  endtask
  // Restartable error sets restart flag, a corrupt one the pointer flag
  task t_restart_pointer_ok;
    xfer(1'b1, 32'h404, 32'h0);
    xfer(1'b1, 32'h408, 32'h0);
    agent.fire(5'h10, 8'h0, 3'h3);
    xfer(1'b0, 32'h408, 32'h0);
    chk(r & 32'h7, 32'h5);
    chk({31'h0, unrecoverable}, 32'h0);
    agent.fire(5'h10, 8'h0, 3'h5);
    xfer(1'b0, 32'h408, 32'h0);
    chk(r & 32'h7, 32'h6);
    xfer(1'b0, 32'h404, 32'h0);
    chk(r & 32'h0200_0000, 32'h0200_0000);
    chk({31'h0, unrecoverable}, 32'h1);
  endtask
  // Second parity failure sets the bit and, with a check pending, shutdown
  task t_apar;
    agent.fire(5'h04, 8'h0);
    xfer(1'b0, 32'h404, 32'h0);
    chk(r & 32'h4000_1000, 32'h0);
    chk({31'h0, shutdown}, 32'h0);
    agent.fire(5'h04, 8'h0);
    xfer(1'b0, 32'h404, 32'h0);
    chk(r & 32'h4000_1000, 32'h4000_1000);
    chk({31'h0, shutdown}, 32'h1);
  endtask
  task t_ecc;
    xfer(1'b1, 32'h404, 32'h0);
    agent.fire(5'h02, 8'ha5);
    xfer(1'b0, 32'h404, 32'h0);
    chk(r & 32'h007f_e000, 32'h0052_a000);
    agent.fire(5'h02, 8'h3c);
    xfer(1'b0, 32'h404, 32'h0);
    chk(r & 32'h007f_e000, 32'h0052_a000);
    xfer(1'b1, 32'h404, 32'h0);
    agent.fire(5'h01, 8'h3c);
    xfer(1'b0, 32'h404, 32'h0);
    chk(r & 32'h007f_e000, 32'h001e_4000);
  endtask
  task t_map;
    xfer(1'b0, 32'h40c, 32'h0);
    chk(r, 32'h1);
    xfer(1'b0, 32'h500, 32'h0);
    chk(r, 32'h0);
    xfer(1'b0, 32'h410, 32'h0);
    chk(r & 32'h1, 32'h1);
  endtask
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_hard;
    t_apar;
    t_ecc;
    t_restart_pointer_ok;
    t_map;
    wrap_up;
  end
endmodule
`default_nettype wire
